/* File: common/chain_irq_defines.svh */
// constants for the daisy-chain interrupt logic
// assumes inclusion by both ends and the package
`ifndef CHAIN_IRQ_DEFINES_SVH
`define CHAIN_IRQ_DEFINES_SVH
`define COND_COUNT 8
`define VECTOR_WIDTH 8
`define VECTOR_RESET 8'h0F
`define CMD_WIDTH 2
`define CMD_NONE 2'h0
`define CMD_SET_CHAIN 2'h1
`define CMD_CLEAR_IN_SERVICE 2'h2
`define CMD_SET_DEFAULT 2'h3
`endif

/* File: common/chain_irq_if.sv */
// link between the device and the host processor
// assumes one clock shared by both ends; data bus modelled by enable
`include "chain_irq_defines.svh"
interface chain_irq_if;
    logic interrupt_request_n;
    logic interrupt_ack_n;
    logic [`VECTOR_WIDTH-1:0] data_out;
    logic data_oe;
    logic [`CMD_WIDTH-1:0] command;
    logic command_valid;
    modport device (
        output interrupt_request_n,
        input interrupt_ack_n,
        output data_out,
        output data_oe,
        input command,
        input command_valid
    );
    modport host (
        input interrupt_request_n,
        output interrupt_ack_n,
        input data_out,
        input data_oe,
        output command,
        output command_valid
    );
endinterface

/* File: common/chain_irq_pkg.sv */
// types used by the host end; the device end does not import them
// assumes the defines header is on the include path
`include "chain_irq_defines.svh"
package chain_irq_pkg;
    typedef logic [`CMD_WIDTH-1:0] command_t;
    typedef logic [`VECTOR_WIDTH-1:0] vector_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT_ACK = 2'b01,
        ST_READ_VEC = 2'b10,
        ST_SERVICE = 2'b11
    } host_state_t;
endpackage

/* File: rtl/chain_irq_device.sv */
// device end: request, acknowledge vector and chain priority logic
// assumes link signals share i_clk; chain input comes from a pin
//
// Behaviour
// RULE_01: reset leaves the default interrupt mode
// RULE_02: only set-chain command enters chain mode
// RULE_03: enabled pending condition drives request low
// RULE_04: request released when causes are cleared
// RULE_05: host answers request with acknowledge low
// RULE_06: acknowledge puts vector on data bus
// RULE_07: chain input high lets unmasked conditions
// RULE_08: masked conditions never raise request
// RULE_09: chain input low suppresses every request (code: only in chain mode; default mode ignores the chain pin)
// RULE_10: chain out high only when idle, enabled
// RULE_11: chain out low until clear-in-service
// RULE_12: service routine ends with clear-in-service
// RULE_13: request drops chain out, blocking lower
// RULE_14: acknowledge marks next cycle vector cycle
// RULE_15: in-service set at vector, cleared by command
`include "chain_irq_defines.svh"
module chain_irq_device #(
    parameter int COND_COUNT = `COND_COUNT
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // link to host
    chain_irq_if.device link,
    // user side
    input wire logic [COND_COUNT-1:0] i_cause,
    input wire logic [COND_COUNT-1:0] i_interrupt_mask,
    input wire logic [`VECTOR_WIDTH-1:0] i_interrupt_vector_register,
    input wire logic i_chain_enable_in,
    output logic o_chain_enable_out,
    output logic o_chain_mode,
    output logic o_in_service_flag
);
    // refuse widths that the cause vector cannot serve
    if (COND_COUNT < 1 || COND_COUNT > 32) begin : g_bad_count
        $error("COND_COUNT out of range");
    end

    logic chain_meta;
    logic chain_in;

    logic chain_mode;
    logic in_service_flag;

    logic ack_prev;
    logic ack_seen;

    logic req_n;
    logic chain_out;
    logic [`VECTOR_WIDTH-1:0] data_reg;
    logic data_oe_reg;

    wire set_chain_cmd;
    wire set_default_cmd;
    wire clear_is_cmd;
    wire [COND_COUNT-1:0] live_cause;
    wire any_cause;
    wire chain_gate;
    wire service_block;
    wire request;
    wire ack_edge;
    wire next_ack_seen;
    wire [`VECTOR_WIDTH-1:0] next_data;
    wire next_chain_out;

    // chain input is a pin: first stage
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            chain_meta <= 1'b0;
        end else begin
            chain_meta <= i_chain_enable_in;
        end
    end

    // second stage; reset low is harmless in default mode
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            chain_in <= 1'b0;
        end else begin
            chain_in <= chain_meta;
        end
    end

    // RULE_02: host command strobe decode
    assign set_chain_cmd = link.command_valid &&
        (link.command == `CMD_SET_CHAIN);
    assign set_default_cmd = link.command_valid &&
        (link.command == `CMD_SET_DEFAULT);
    assign clear_is_cmd = link.command_valid &&
        (link.command == `CMD_CLEAR_IN_SERVICE);

    // RULE_08: mask gates each cause
    for (genvar i = 0; i < COND_COUNT; i++) begin : g_gate
        assign live_cause[i] = i_cause[i] && i_interrupt_mask[i];
    end
    assign any_cause = |live_cause;

    // RULE_07: chain pin in chain mode
    // RULE_09: low chain pin suppresses all in chain mode
    assign chain_gate = !chain_mode || chain_in;
    // in-service holds off a second request until cleared
    assign service_block = chain_mode && in_service_flag;
    // RULE_03: cause raises request
    assign request = any_cause && chain_gate && !service_block;
    // RULE_14: acknowledge edge while asking
    assign ack_edge = chain_mode && !link.interrupt_ack_n && ack_prev;
    assign next_ack_seen = ack_edge && !req_n;
    // bus idles at zero outside the vector cycle
    assign next_data = ack_seen ? i_interrupt_vector_register : '0;
    // RULE_10: chain out when idle
    assign next_chain_out = chain_mode && chain_in && !request &&
        !in_service_flag;

    // RULE_01: default mode after reset
    // RULE_02: chain mode only by command
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            chain_mode <= 1'b0;
        end else if (set_chain_cmd) begin
            chain_mode <= 1'b1;
        end else if (set_default_cmd) begin
            chain_mode <= 1'b0;
        end
    end

    // RULE_03: request drives line low
    // RULE_04: released once causes gone
    // registered: a cycle late, but the pin never glitches
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            req_n <= 1'b1;
        end else begin
            req_n <= !request;
        end
    end

    // RULE_13: chain out falls with request
    // RULE_11: low until clear-in-service
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            chain_out <= 1'b0;
        end else begin
            chain_out <= next_chain_out;
        end
    end

    // resets to the idle pin level: no false edge after reset
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack_prev <= 1'b1;
        end else begin
            ack_prev <= link.interrupt_ack_n;
        end
    end

    // RULE_14: edge marks vector cycle
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack_seen <= 1'b0;
        end else begin
            ack_seen <= next_ack_seen;
        end
    end

    // RULE_06: vector enable one cycle
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            data_oe_reg <= 1'b0;
        end else begin
            data_oe_reg <= ack_seen;
        end
    end

    // RULE_06: vector onto bus
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            data_reg <= '0;
        end else begin
            data_reg <= next_data;
        end
    end

    // RULE_15: set at vector, set wins
    // RULE_11: held until clear-in-service
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            in_service_flag <= 1'b0;
        end else if (ack_seen) begin
            in_service_flag <= 1'b1;
        end else if (clear_is_cmd) begin
            in_service_flag <= 1'b0;
        end
    end

    // every output straight from a flop
    assign link.interrupt_request_n = req_n;
    assign link.data_out = data_reg;
    assign link.data_oe = data_oe_reg;
    assign o_chain_enable_out = chain_out;
    assign o_chain_mode = chain_mode;
    assign o_in_service_flag = in_service_flag;
endmodule

/* File: rtl/chain_irq_host.sv */
// host end: answers requests, reads vector, clears in-service
// assumes the device shares i_clk; service length set by user
`include "chain_irq_defines.svh"
module chain_irq_host (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // link to device
    chain_irq_if.host link,
    // user side
    input wire logic i_set_chain,
    input wire logic i_set_default,
    input wire logic i_service_done,
    output logic o_vector_valid,
    output logic [`VECTOR_WIDTH-1:0] o_vector,
    output logic o_busy
);
    chain_irq_pkg::host_state_t state;
    chain_irq_pkg::host_state_t next_state;
    logic ack_n;
    logic cmd_valid;
    chain_irq_pkg::command_t cmd;
    logic vec_valid;
    logic [`VECTOR_WIDTH-1:0] vec;
    logic busy;
    logic chain_known;

    wire req_seen = !link.interrupt_request_n;
    wire vec_here = link.data_oe;
    // RULE_05: only chain mode is acknowledged
    wire answer_req = req_seen && chain_known;
    wire finish_service = (state == chain_irq_pkg::ST_SERVICE) &&
        i_service_done;

    always_comb begin
        next_state = state;
        unique case (state)
            chain_irq_pkg::ST_IDLE:
                if (answer_req) next_state = chain_irq_pkg::ST_WAIT_ACK;
            chain_irq_pkg::ST_WAIT_ACK:
                next_state = chain_irq_pkg::ST_READ_VEC;
            chain_irq_pkg::ST_READ_VEC: begin
                // a withdrawn request must not strand the host
                if (vec_here) begin
                    next_state = chain_irq_pkg::ST_SERVICE;
                end else if (!req_seen) begin
                    next_state = chain_irq_pkg::ST_IDLE;
                end
            end
            chain_irq_pkg::ST_SERVICE:
                if (i_service_done) next_state = chain_irq_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= chain_irq_pkg::ST_IDLE;
            ack_n <= 1'b1;
            vec_valid <= 1'b0;
            vec <= '0;
            busy <= 1'b0;
        end else begin
            state <= next_state;
            busy <= (next_state != chain_irq_pkg::ST_IDLE);
            // RULE_05: acknowledge a detected request
            ack_n <= !(next_state == chain_irq_pkg::ST_WAIT_ACK ||
                next_state == chain_irq_pkg::ST_READ_VEC);
            vec_valid <= (state == chain_irq_pkg::ST_READ_VEC) && vec_here;
            if ((state == chain_irq_pkg::ST_READ_VEC) && vec_here) begin
                vec <= link.data_out;
            end
        end
    end

    // RULE_12: clear-in-service ends every service
    // RULE_02: chain mode entered by command
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cmd_valid <= 1'b0;
            cmd <= `CMD_NONE;
        end else if (finish_service) begin
            cmd_valid <= 1'b1;
            cmd <= `CMD_CLEAR_IN_SERVICE;
        end else if (i_set_chain) begin
            cmd_valid <= 1'b1;
            cmd <= `CMD_SET_CHAIN;
        end else if (i_set_default) begin
            cmd_valid <= 1'b1;
            cmd <= `CMD_SET_DEFAULT;
        end else begin
            cmd_valid <= 1'b0;
            cmd <= `CMD_NONE;
        end
    end

    // mode as last commanded; same priority as the command strobe
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            chain_known <= 1'b0;
        end else if (!finish_service && i_set_chain) begin
            chain_known <= 1'b1;
        end else if (!finish_service && i_set_default) begin
            chain_known <= 1'b0;
        end
    end

    assign link.interrupt_ack_n = ack_n;
    assign link.command = cmd;
    assign link.command_valid = cmd_valid;
    assign o_vector_valid = vec_valid;
    assign o_vector = vec;
    assign o_busy = busy;
endmodule

/* File: tb/chain_irq_chk.sv */
// link checker for the device and host ends
// assumes one clock shared by both ends
`include "chain_irq_defines.svh"
module chain_irq_chk (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic interrupt_request_n,
    input wire logic interrupt_ack_n,
    input wire logic [`VECTOR_WIDTH-1:0] data_out,
    input wire logic data_oe,
    input wire logic [`CMD_WIDTH-1:0] command,
    input wire logic command_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic mode;
    logic svc;
    wire is_clear = command_valid && command == `CMD_CLEAR_IN_SERVICE;
    wire is_mode = command_valid && command[0];
    wire blk = mode && svc;
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    // mode and in-service rebuilt from link traffic only
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode <= 1'b0;
            svc <= 1'b0;
        end else begin
            if (is_mode)
                mode <= !command[1];
            if (is_clear)
                svc <= 1'b0;
            else if (data_oe)
                svc <= 1'b1;
        end
    end
    vec_single_a: assert property (data_oe |=> !data_oe [*2])
        else $error("vector enable held too long");
    vec_on_ack_a: assert property (mode && $fell(interrupt_ack_n)
        && !interrupt_request_n |-> ##2 data_oe) else $error("no vector");
    vec_cause_a: assert property ($rose(data_oe) |->
        !$past(interrupt_ack_n, 2) && !$past(interrupt_request_n, 2))
        else $error("vector without acknowledge");
    default_quiet_a: assert property (!mode |-> !data_oe)
        else $error("vector in default mode");
    default_ack_a: assert property (!mode && $fell(interrupt_ack_n)
        |-> ##2 !data_oe) else $error("default mode took acknowledge");
    svc_block_a: assert property ($past(blk) && blk
        |-> interrupt_request_n) else $error("request while in service");
    ack_answers_a: assert property ($fell(interrupt_ack_n)
        |-> !interrupt_request_n) else $error("acknowledge without request");
    ack_release_a: assert property ($rose(data_oe)
        |-> ##[0:20] interrupt_ack_n) else $error("acknowledge not released");
    cover property ($rose(data_oe));
    cover property (mode && !interrupt_request_n);
    cover property (is_clear);
endmodule

/* File: tb/test_daisy_chain_interrupt_logic.sv */
// testbench: device and host joined, one task per scenario
// assumes 50 MHz clock and the shared defines header
`include "chain_irq_defines.svh"
module test_daisy_chain_interrupt_logic;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [7:0] i_cause = 8'h00;
    logic [7:0] mask = 8'hFF;
    logic [7:0] vreg = 8'hA5;
    logic chain_in = 1'b1;
    logic set_chain = 1'b0;
    logic set_default = 1'b0;
    logic done = 1'b0;
    logic cout, mode, isf, vvalid, busy;
    logic [7:0] vec;
    int fail_count = 0;
    int cmp_count = 0;
    chain_irq_if link();
    wire req = link.interrupt_request_n;
    chain_irq_device chain_irq_device_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .link(link), .i_cause(i_cause), .i_interrupt_mask(mask),
        .i_interrupt_vector_register(vreg), .i_chain_enable_in(chain_in),
        .o_chain_enable_out(cout), .o_chain_mode(mode),
        .o_in_service_flag(isf));
    chain_irq_host chain_irq_host_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .link(link), .i_set_chain(set_chain), .i_service_done(done),
        .i_set_default(set_default),
        .o_vector_valid(vvalid), .o_vector(vec), .o_busy(busy));
    chain_irq_chk chain_irq_chk_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .interrupt_request_n(link.interrupt_request_n),
        .interrupt_ack_n(link.interrupt_ack_n), .data_out(link.data_out),
        .data_oe(link.data_oe), .command(link.command),
        .command_valid(link.command_valid));
    always #10 i_clk = ~i_clk;
    task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // sampling on the falling edge keeps clear of launch races
    task automatic tick(int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic t_default();
        chk("mode", mode, 0);
        chk("req", req, 1);
        @(posedge i_clk);
        i_cause <= 8'h10;
        chain_in <= 1'b0;
        tick(5);
        chk("req", req, 0);
        chk("cout", cout, 0);
        @(posedge i_clk);
        mask <= 8'hEF;
        tick(3);
        chk("req", req, 1);
        $display("default mode test done");
    endtask
    task automatic t_chain();
        int n;
        @(posedge i_clk) set_chain <= 1'b1;
        @(posedge i_clk) set_chain <= 1'b0;
        tick(4);
        chk("mode", mode, 1);
        chk("cout", cout, 1);
        @(posedge i_clk) chain_in <= 1'b0;
        tick(4);
        chk("cout", cout, 0);
        @(posedge i_clk) i_cause <= 8'h01;
        tick(4);
        chk("req", req, 1);
        @(posedge i_clk) chain_in <= 1'b1;
        for (n = 0; n < 30 && vvalid !== 1'b1; n++)
            @(negedge i_clk);
        chk("vvalid", vvalid, 1);
        chk("vec", vec, 8'hA5);
        chk("isf", isf, 1);
        chk("cout", cout, 0);
        chk("busy", busy, 1);
        @(posedge i_clk) i_cause <= 8'h00;
        tick(6);
        chk("req", req, 1);
        chk("cout", cout, 0);
        @(posedge i_clk) done <= 1'b1;
        @(posedge i_clk) done <= 1'b0;
        tick(5);
        chk("isf", isf, 0);
        chk("cout", cout, 1);
        chk("busy", busy, 0);
        @(posedge i_clk);
        mask <= 8'h00;
        i_cause <= 8'hFF;
        tick(5);
        chk("req", req, 1);
        chk("cout", cout, 1);
        @(posedge i_clk) mask <= 8'hFF;
        tick(2);
        chk("req", req, 0);
        chk("cout", cout, 0);
        for (n = 0; n < 30 && vvalid !== 1'b1; n++)
            @(negedge i_clk);
        chk("vec", vec, 8'hA5);
        @(posedge i_clk);
        i_cause <= 8'h00;
        done <= 1'b1;
        @(posedge i_clk) done <= 1'b0;
        tick(5);
        chk("isf", isf, 0);
        chk("req", req, 1);
        $display("chain mode test done");
    endtask
    task automatic t_back_default();
        @(posedge i_clk) set_default <= 1'b1;
        @(posedge i_clk) set_default <= 1'b0;
        tick(3);
        chk("mode", mode, 0);
        @(posedge i_clk);
        chain_in <= 1'b0;
        i_cause <= 8'h02;
        tick(5);
        chk("req", req, 0);
        chk("cout", cout, 0);
        chk("busy", busy, 0);
        chk("vvalid", vvalid, 0);
        @(posedge i_clk) i_cause <= 8'h00;
        tick(3);
        chk("req", req, 1);
        $display("return to default test done");
    endtask
    initial begin
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        tick(1);
        t_default();
        // mid-run reset, released with the chain pin high
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        i_cause <= 8'h00;
        mask <= 8'hFF;
        chain_in <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        tick(3);
        t_chain();
        t_back_default();
        conclude();
    end
    initial begin
        #20000;
        fail_count++;
        conclude();
    end
endmodule
